// ### logic/raid6_ctrl_pkg.sv
// shared constants and types for the parity update control block
`default_nettype none
package raid6_ctrl_pkg;
	// register offsets on the control register bus
	localparam logic [9:0] OFS_REQUEST  = 10'h180;
	localparam logic [9:0] OFS_LOST     = 10'h181;
	localparam logic [9:0] OFS_DATA_ONE = 10'h182;
	localparam logic [9:0] OFS_DATA_TWO = 10'h183;
	localparam logic [9:0] OFS_DATA_THR = 10'h184;
	localparam logic [9:0] OFS_DATA_FOU = 10'h185;
	localparam logic [9:0] OFS_P_BASE   = 10'h186;
	localparam logic [9:0] OFS_Q_BASE   = 10'h187;
	localparam logic [9:0] OFS_OP_SEL   = 10'h188;
	localparam logic [9:0] OFS_RESERVED = 10'h189;
	localparam logic [9:0] OFS_LAMP     = 10'h18a;
	localparam logic [9:0] OFS_LEN_SEL  = 10'h18b;
	localparam logic [31:0] REG_RESET   = 32'h0000_0000;
	// field positions
	localparam int REQ_BIT    = 0;
	localparam int OP_MSB     = 31;
	localparam int OP_LSB     = 29;
	localparam int LAMP_BIT   = 0;
	localparam logic [2:0] OP_UPDATE = 3'h3;
	// block length codes, low five bits of the length register
	localparam logic [4:0] LEN_512 = 5'h00;
	localparam logic [4:0] LEN_1K  = 5'h01;
	localparam logic [4:0] LEN_2K  = 5'h04;
	localparam logic [4:0] LEN_8K  = 5'h08;
	localparam logic [4:0] LEN_16K = 5'h10;
	localparam logic [12:0] WORDS_512 = 13'h0080;
	localparam logic [12:0] WORDS_1K  = 13'h0100;
	localparam logic [12:0] WORDS_2K  = 13'h0200;
	localparam logic [12:0] WORDS_8K  = 13'h0800;
	localparam logic [12:0] WORDS_16K = 13'h1000;
	localparam int BUF_DEPTH = 4096;
	// one memory grant moves 128 bytes, 32 words
	localparam logic [5:0] BURST_WORDS = 6'h20;
	localparam int BURST_SHIFT = 7;
	// galois field
	localparam logic [7:0] GF_POLY  = 8'h1d;
	localparam logic [7:0] GF_UNITY = 8'h01;
	// output selector codes
	localparam logic [1:0] SEL_ACC  = 2'h0;
	localparam logic [1:0] SEL_SEC  = 2'h1;
	localparam logic [1:0] SEL_THR  = 2'h2;
	localparam logic [1:0] SEL_FOU  = 2'h3;

	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_RD_REQ  = 3'b001,
		ST_RD_DATA = 3'b010,
		ST_MIX     = 3'b011,
		ST_WR_REQ  = 3'b100,
		ST_WR_DATA = 3'b101,
		ST_WR_WAIT = 3'b110,
		ST_FINISH  = 3'b111
	} fsm_t;

	typedef enum logic [2:0] {
		PH_OLD_DATA = 3'b000,
		PH_NEW_DATA = 3'b001,
		PH_OLD_P    = 3'b010,
		PH_OLD_Q    = 3'b011,
		PH_WR_P     = 3'b100,
		PH_WR_Q     = 3'b101
	} phase_t;

	typedef struct packed {
		logic d2;
		logic d1;
		logic d0;
		logic p;
		logic q;
	} lost_set_t;

	typedef struct packed {
		fsm_t        fsm;
		phase_t      phase;
		logic [11:0] widx;
		logic [5:0]  bcnt;
		logic        req;
		logic        done;
		logic [31:0] lost;
		logic [31:0] d_one;
		logic [31:0] d_two;
		logic [31:0] d_thr;
		logic [31:0] d_fou;
		logic [31:0] p_base;
		logic [31:0] q_base;
		logic [31:0] op_sel;
		logic [31:0] lamp;
		logic [31:0] len_sel;
		logic [31:0] rdata;
		logic        ack;
		logic        mem_req;
		logic        mem_rnw;
		logic [31:0] mem_addr;
		logic        wr_valid;
		logic [31:0] wr_data;
		logic [31:0] q_hold;
		logic [11:0] q_idx;
		logic        q_pend;
		lost_set_t   lost_set;
	} ctrl_state_t;
endpackage
`default_nettype wire

// ### logic/raid6_parity_update_control.sv
// parity update control: registers, main state machine, buffers
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - old data fills accumulation and first buffer
// - new data to third; accumulate XOR
// - first XOR unity-scaled third into second
// - old P XOR accumulation back to accumulation
// - registered old Q XOR second into fourth
// - new P from accumulation through selector
// - then new Q from fourth buffer
// - one state machine drives all controls
// - writing one to request bit starts
// - request bit clears on completion
// - lost-member low five bits passed through as bit set
// - separate base pointers per block
// - mode bits 31 to 29 select operation
// - update uses pointers one and two
// - length register sets block size
// - indicator register drives status lamp
// - engine writes only the request register
// - 128-byte bursts, repeated per block
// - completion output high when finished
// - operation begins while start high
module raid6_parity_update_control
(
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        start_i,
	input  wire logic [9:0]  dcr_addr_i,
	input  wire logic        dcr_rd_i,
	input  wire logic        dcr_wr_i,
	input  wire logic [31:0] dcr_wdata_i,
	output logic      [31:0] dcr_rdata_o,
	output logic             dcr_ack_o,
	output logic             mem_req_o,
	output logic             mem_rnw_o,
	output logic      [31:0] mem_addr_o,
	input  wire logic        mem_ack_i,
	input  wire logic        mem_rd_valid_i,
	input  wire logic [31:0] mem_rd_data_i,
	output logic             mem_wr_valid_o,
	output logic      [31:0] mem_wr_data_o,
	input  wire logic        mem_wr_ready_i,
	input  wire logic        mem_wr_cmpl_i,
	output logic             done_o,
	output logic             lamp_o,
	output logic      [4:0]  lost_members_o
);

	// --------------------------------------------------
	// helper functions
	// --------------------------------------------------
	function automatic logic [7:0] gf_mul8(input logic [7:0] a,
		input logic [7:0] b);
		logic [7:0] acc;
		logic [7:0] sh;
		acc = 8'h00;
		sh = a;
		for (int i = 0; i < 8; i++)
		begin
			if (b[i])
				acc = acc ^ sh;
			sh = sh[7] ? ({sh[6:0], 1'b0} ^ raid6_ctrl_pkg::GF_POLY)
				: {sh[6:0], 1'b0};
		end
		return acc;
	endfunction

	function automatic logic [31:0] gf_scale(input logic [31:0] d,
		input logic [7:0] g);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
			r[i*8 +: 8] = gf_mul8(d[i*8 +: 8], g);
		return r;
	endfunction

	function automatic logic [12:0] block_words(input logic [4:0] c);
		logic [12:0] w;
		w = raid6_ctrl_pkg::WORDS_512;
		if (c == raid6_ctrl_pkg::LEN_1K)
			w = raid6_ctrl_pkg::WORDS_1K;
		else if (c == raid6_ctrl_pkg::LEN_2K)
			w = raid6_ctrl_pkg::WORDS_2K;
		else if (c == raid6_ctrl_pkg::LEN_8K)
			w = raid6_ctrl_pkg::WORDS_8K;
		else if (c == raid6_ctrl_pkg::LEN_16K)
			w = raid6_ctrl_pkg::WORDS_16K;
		return w;
	endfunction

	// --------------------------------------------------
	// state and buffers
	// --------------------------------------------------
	raid6_ctrl_pkg::ctrl_state_t s;
	raid6_ctrl_pkg::ctrl_state_t next_s;

	logic [31:0] acc_buf [raid6_ctrl_pkg::BUF_DEPTH];
	logic [31:0] m0_buf  [raid6_ctrl_pkg::BUF_DEPTH];
	logic [31:0] m1_buf  [raid6_ctrl_pkg::BUF_DEPTH];
	logic [31:0] m2_buf  [raid6_ctrl_pkg::BUF_DEPTH];
	logic [31:0] m3_buf  [raid6_ctrl_pkg::BUF_DEPTH];

	logic        acc_we;
	logic        m0_we;
	logic        m1_we;
	logic        m2_we;
	logic        m3_we;
	logic [31:0] acc_wd;
	logic [31:0] m1_wd;
	logic [31:0] m2_wd;
	logic [31:0] m3_wd;
	logic [31:0] rd_word;
	logic [12:0] len_words;
	logic [31:0] sel_word;
	logic [1:0]  out_sel;
	logic [31:0] blk_base;
	logic        last_word;

	// --------------------------------------------------
	// datapath decode
	// --------------------------------------------------
	assign rd_word   = mem_rd_data_i;
	assign len_words = block_words(s.len_sel[4:0]);
	assign last_word = ({1'b0, s.widx} + 13'h0001) == len_words;

	// 4:1 output selector
	always_comb
	begin
		out_sel = (s.phase == raid6_ctrl_pkg::PH_WR_P)
			? raid6_ctrl_pkg::SEL_ACC : raid6_ctrl_pkg::SEL_FOU;
		if (out_sel == raid6_ctrl_pkg::SEL_ACC)
			sel_word = acc_buf[s.widx];
		else if (out_sel == raid6_ctrl_pkg::SEL_SEC)
			sel_word = m1_buf[s.widx];
		else if (out_sel == raid6_ctrl_pkg::SEL_THR)
			sel_word = m2_buf[s.widx];
		else
			sel_word = m3_buf[s.widx];
	end

	// base pointer per phase
	always_comb
	begin
		case (s.phase)
			raid6_ctrl_pkg::PH_OLD_DATA: blk_base = s.d_one;
			raid6_ctrl_pkg::PH_NEW_DATA: blk_base = s.d_two;
			raid6_ctrl_pkg::PH_OLD_P:    blk_base = s.p_base;
			raid6_ctrl_pkg::PH_WR_P:     blk_base = s.p_base;
			default:                     blk_base = s.q_base;
		endcase
	end

	// --------------------------------------------------
	// main state machine and register file
	// --------------------------------------------------
	always_comb
	begin
		next_s = s;
		acc_we = 1'b0;
		m0_we = 1'b0;
		m1_we = 1'b0;
		m2_we = 1'b0;
		m3_we = 1'b0;
		acc_wd = rd_word;
		m1_wd = m0_buf[s.widx] ^ gf_scale(m2_buf[s.widx],
			raid6_ctrl_pkg::GF_UNITY);
		m2_wd = rd_word;
		m3_wd = s.q_hold ^ m1_buf[s.q_idx];
		next_s.ack = 1'b0;

		// registered old Q word lands one cycle later
		if (s.q_pend)
		begin
			m3_we = 1'b1;
			next_s.q_pend = 1'b0;
		end

		case (s.fsm)
			raid6_ctrl_pkg::ST_IDLE:
			begin
				if (s.req && start_i)
				begin
					next_s.widx = 12'h000;
					next_s.done = 1'b0;
					next_s.phase = raid6_ctrl_pkg::PH_OLD_DATA;
					if (s.op_sel[raid6_ctrl_pkg::OP_MSB:
						raid6_ctrl_pkg::OP_LSB] ==
						raid6_ctrl_pkg::OP_UPDATE)
						next_s.fsm = raid6_ctrl_pkg::ST_RD_REQ;
					else
						next_s.fsm = raid6_ctrl_pkg::ST_FINISH;
				end
			end
			raid6_ctrl_pkg::ST_RD_REQ:
			begin
				next_s.mem_req = 1'b1;
				next_s.mem_rnw = 1'b1;
				next_s.mem_addr = blk_base +
					{18'h00000, s.widx, 2'b00};
				if (s.mem_req && mem_ack_i)
				begin
					next_s.mem_req = 1'b0;
					next_s.bcnt = 6'h00;
					next_s.fsm = raid6_ctrl_pkg::ST_RD_DATA;
				end
			end
			raid6_ctrl_pkg::ST_RD_DATA:
			begin
				if (mem_rd_valid_i)
				begin
					case (s.phase)
						raid6_ctrl_pkg::PH_OLD_DATA:
						begin
							acc_we = 1'b1;
							m0_we = 1'b1;
						end
						raid6_ctrl_pkg::PH_NEW_DATA:
						begin
							m2_we = 1'b1;
							acc_we = 1'b1;
							acc_wd = acc_buf[s.widx] ^ rd_word;
						end
						raid6_ctrl_pkg::PH_OLD_P:
						begin
							acc_we = 1'b1;
							acc_wd = acc_buf[s.widx] ^ rd_word;
						end
						default:
						begin
							next_s.q_hold = rd_word;
							next_s.q_idx = s.widx;
							next_s.q_pend = 1'b1;
						end
					endcase
					next_s.widx = s.widx + 12'h001;
					next_s.bcnt = s.bcnt + 6'h01;
					if (s.bcnt == raid6_ctrl_pkg::BURST_WORDS - 6'h01)
					begin
						next_s.fsm = raid6_ctrl_pkg::ST_RD_REQ;
						if (last_word)
						begin
							next_s.widx = 12'h000;
							case (s.phase)
								raid6_ctrl_pkg::PH_OLD_DATA:
									next_s.phase = raid6_ctrl_pkg::PH_NEW_DATA;
								raid6_ctrl_pkg::PH_NEW_DATA:
									next_s.fsm = raid6_ctrl_pkg::ST_MIX;
								raid6_ctrl_pkg::PH_OLD_P:
									next_s.phase = raid6_ctrl_pkg::PH_OLD_Q;
								default:
								begin
									next_s.phase = raid6_ctrl_pkg::PH_WR_P;
									next_s.fsm = raid6_ctrl_pkg::ST_WR_REQ;
								end
							endcase
						end
					end
				end
			end
			raid6_ctrl_pkg::ST_MIX:
			begin
				m1_we = 1'b1;
				next_s.widx = s.widx + 12'h001;
				if (last_word)
				begin
					next_s.widx = 12'h000;
					next_s.phase = raid6_ctrl_pkg::PH_OLD_P;
					next_s.fsm = raid6_ctrl_pkg::ST_RD_REQ;
				end
			end
			raid6_ctrl_pkg::ST_WR_REQ:
			begin
				next_s.mem_req = 1'b1;
				next_s.mem_rnw = 1'b0;
				next_s.mem_addr = blk_base +
					{18'h00000, s.widx, 2'b00};
				if (s.mem_req && mem_ack_i)
				begin
					next_s.mem_req = 1'b0;
					next_s.bcnt = 6'h00;
					next_s.fsm = raid6_ctrl_pkg::ST_WR_DATA;
				end
			end
			raid6_ctrl_pkg::ST_WR_DATA:
			begin
				if (!s.wr_valid || mem_wr_ready_i)
				begin
					if (s.bcnt != raid6_ctrl_pkg::BURST_WORDS)
					begin
						next_s.wr_valid = 1'b1;
						next_s.wr_data = sel_word;
						next_s.widx = s.widx + 12'h001;
						next_s.bcnt = s.bcnt + 6'h01;
					end
					else
					begin
						next_s.wr_valid = 1'b0;
						next_s.fsm = raid6_ctrl_pkg::ST_WR_WAIT;
					end
				end
			end
			raid6_ctrl_pkg::ST_WR_WAIT:
			begin
				if (mem_wr_cmpl_i)
				begin
					next_s.fsm = raid6_ctrl_pkg::ST_WR_REQ;
					if (s.widx == len_words[11:0])
					begin
						next_s.widx = 12'h000;
						if (s.phase == raid6_ctrl_pkg::PH_WR_P)
							next_s.phase = raid6_ctrl_pkg::PH_WR_Q;
						else
							next_s.fsm = raid6_ctrl_pkg::ST_FINISH;
					end
				end
			end
			default:
			begin
				next_s.req = 1'b0;
				next_s.done = 1'b1;
				next_s.fsm = raid6_ctrl_pkg::ST_IDLE;
			end
		endcase

		// processor side; a software write beats the hardware clear
		if (dcr_wr_i)
		begin
			next_s.ack = 1'b1;
			if (dcr_addr_i == raid6_ctrl_pkg::OFS_REQUEST)
				next_s.req = dcr_wdata_i[raid6_ctrl_pkg::REQ_BIT];
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_LOST)
				next_s.lost = dcr_wdata_i;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_DATA_ONE)
				next_s.d_one = dcr_wdata_i;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_DATA_TWO)
				next_s.d_two = dcr_wdata_i;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_DATA_THR)
				next_s.d_thr = dcr_wdata_i;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_DATA_FOU)
				next_s.d_fou = dcr_wdata_i;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_P_BASE)
				next_s.p_base = dcr_wdata_i;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_Q_BASE)
				next_s.q_base = dcr_wdata_i;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_OP_SEL)
				next_s.op_sel = dcr_wdata_i;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_LAMP)
				next_s.lamp = dcr_wdata_i;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_LEN_SEL)
				next_s.len_sel = dcr_wdata_i;
		end

		if (dcr_rd_i)
		begin
			next_s.ack = 1'b1;
			next_s.rdata = 32'h0000_0000;
			if (dcr_addr_i == raid6_ctrl_pkg::OFS_REQUEST)
				next_s.rdata = {31'h0000_0000, s.req};
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_LOST)
				next_s.rdata = s.lost;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_DATA_ONE)
				next_s.rdata = s.d_one;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_DATA_TWO)
				next_s.rdata = s.d_two;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_DATA_THR)
				next_s.rdata = s.d_thr;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_DATA_FOU)
				next_s.rdata = s.d_fou;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_P_BASE)
				next_s.rdata = s.p_base;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_Q_BASE)
				next_s.rdata = s.q_base;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_OP_SEL)
				next_s.rdata = s.op_sel;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_LAMP)
				next_s.rdata = s.lamp;
			else if (dcr_addr_i == raid6_ctrl_pkg::OFS_LEN_SEL)
				next_s.rdata = s.len_sel;
		end

		// lost-member bit set
		next_s.lost_set = raid6_ctrl_pkg::lost_set_t'(s.lost[4:0]);
	end

	// --------------------------------------------------
	// registers
	// --------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			s <= '0;
			s.fsm <= raid6_ctrl_pkg::ST_IDLE;
			s.phase <= raid6_ctrl_pkg::PH_OLD_DATA;
			s.len_sel <= raid6_ctrl_pkg::REG_RESET;
		end
		else
			s <= next_s;
	end

	// buffer writes, engine side only
	always_ff @(posedge ref_clk_i)
	begin
		if (acc_we)
			acc_buf[s.widx] <= acc_wd;
		if (m0_we)
			m0_buf[s.widx] <= rd_word;
		if (m1_we)
			m1_buf[s.widx] <= m1_wd;
		if (m2_we)
			m2_buf[s.widx] <= m2_wd;
		if (m3_we)
			m3_buf[s.q_idx] <= m3_wd;
	end

	// --------------------------------------------------
	// outputs
	// --------------------------------------------------
	assign dcr_rdata_o    = s.rdata;
	assign dcr_ack_o      = s.ack;
	assign mem_req_o      = s.mem_req;
	assign mem_rnw_o      = s.mem_rnw;
	assign mem_addr_o     = s.mem_addr;
	assign mem_wr_valid_o = s.wr_valid;
	assign mem_wr_data_o  = s.wr_data;
	assign done_o         = s.done;
	assign lamp_o         = s.lamp[raid6_ctrl_pkg::LAMP_BIT];
	assign lost_members_o = s.lost_set;

endmodule
`default_nettype wire

// ### sim/mem_partner.sv
// memory port model: grants, read bursts, write bursts
`timescale 1ns/10ps
`default_nettype none
module mem_partner
(
	input wire logic         ref_clk_i,
	input wire logic         mem_req_o,
	input wire logic         mem_rnw_o,
	input wire logic  [31:0] mem_addr_o,
	input wire logic         mem_wr_valid_o,
	input wire logic  [31:0] mem_wr_data_o,
	output var logic         mem_ack_i,
	output var logic         mem_rd_valid_i,
	output var logic  [31:0] mem_rd_data_i,
	output var logic         mem_wr_ready_i,
	output var logic         mem_wr_cmpl_i
);
	logic [31:0] wmem [logic [31:0]];

	function automatic logic [31:0] word_at(input logic [31:0] a);
		return (a * 32'h9e37_79b1) ^ 32'h5a5a_0f0f;
	endfunction

	initial
	begin
		logic [31:0] a;
		logic        rnw;
		int          i;
		mem_ack_i = 1'b0;
		mem_rd_valid_i = 1'b0;
		mem_rd_data_i = 32'h0;
		mem_wr_ready_i = 1'b0;
		mem_wr_cmpl_i = 1'b0;
		forever
		begin
			@(posedge ref_clk_i);
			#1;
			if (mem_req_o)
			begin
				a = mem_addr_o;
				rnw = mem_rnw_o;
				repeat ($urandom_range(3)) @(posedge ref_clk_i);
				#1 mem_ack_i = 1'b1;
				@(posedge ref_clk_i);
				#1 mem_ack_i = 1'b0;
				i = 0;
				while (i < 32)
				begin
					if (rnw)
					begin
						if ($urandom_range(1))
						begin
							mem_rd_valid_i = 1'b1;
							mem_rd_data_i = word_at(a + 32'(4 * i));
							i++;
						end
						@(posedge ref_clk_i);
						#1 mem_rd_valid_i = 1'b0;
						mem_rd_data_i = ~mem_rd_data_i;
					end
					else
					begin
						mem_wr_ready_i = 1'($urandom_range(1));
						@(posedge ref_clk_i);
						if (mem_wr_ready_i && mem_wr_valid_o)
						begin
							wmem[a + 32'(4 * i)] = mem_wr_data_o;
							i++;
						end
						#1 mem_wr_ready_i = 1'b0;
					end
				end
				if (!rnw)
				begin
					mem_wr_cmpl_i = 1'b1;
					@(posedge ref_clk_i);
					#1 mem_wr_cmpl_i = 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the parity update control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic        ref_clk_i, sys_rst_i, start_i, dcr_rd_i, dcr_wr_i;
	logic        dcr_ack_o, mem_req_o, mem_rnw_o, mem_ack_i;
	logic        mem_rd_valid_i, mem_wr_valid_o, mem_wr_ready_i;
	logic        mem_wr_cmpl_i, done_o, lamp_o;
	logic [9:0]  dcr_addr_i;
	logic [4:0]  lost_members_o;
	logic [31:0] dcr_wdata_i, dcr_rdata_o, mem_addr_o, mem_rd_data_i;
	logic [31:0] mem_wr_data_o;
	logic [31:0] base [6];
	int          n_fail, checks_done, n_rd, n_wr;

	raid6_parity_update_control DUT (.*);
	mem_partner mdl (.*);

	initial
	begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end

	// burst counts per direction
	always @(posedge ref_clk_i)
		if (mem_req_o && mem_ack_i)
			if (mem_rnw_o)
				n_rd++;
			else
				n_wr++;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic dcr_wr(input logic [9:0] a, input logic [31:0] d);
		dcr_addr_i = a;
		dcr_wdata_i = d;
		dcr_wr_i = 1'b1;
		@(posedge ref_clk_i);
		#1 dcr_wr_i = 1'b0;
		check(dcr_ack_o, 1'b1);
		@(posedge ref_clk_i);
		#1;
	endtask

	task automatic dcr_rd(input logic [9:0] a, output logic [31:0] d);
		dcr_addr_i = a;
		dcr_rd_i = 1'b1;
		@(posedge ref_clk_i);
		#1 dcr_rd_i = 1'b0;
		d = dcr_rdata_o;
		@(posedge ref_clk_i);
		#1;
	endtask

	function automatic int words_of(input logic [4:0] c);
		case (c)
			5'h01: return 256;
			5'h04: return 512;
			5'h08: return 2048;
			5'h10: return 4096;
			default: return 128;
		endcase
	endfunction

	task automatic run_op(input logic [2:0] op, input logic [4:0] len);
		logic [31:0] d;
		int          k;
		int          w;
		w = words_of(len);
		n_rd = 0;
		n_wr = 0;
		mdl.wmem.delete();
		dcr_wr(raid6_ctrl_pkg::OFS_OP_SEL, {op, 29'h0});
		dcr_wr(raid6_ctrl_pkg::OFS_LEN_SEL, {27'h0, len});
		dcr_wr(raid6_ctrl_pkg::OFS_REQUEST, 32'h1);
		d = 32'h1;
		for (k = 0; k < 10000 && d[0] !== 1'b0; k++)
			dcr_rd(raid6_ctrl_pkg::OFS_REQUEST, d);
		check(d, 32'h0);
		check(done_o, 1'b1);
		check(n_rd, op == 3'h3 ? w / 8 : 0);
		check(n_wr, op == 3'h3 ? w / 16 : 0);
		for (k = 0; op == 3'h3 && k < w; k++)
		begin
			d = mdl.word_at(base[0] + 32'(4 * k));
			d = d ^ mdl.word_at(base[1] + 32'(4 * k));
			check(mdl.wmem[base[4] + 32'(4 * k)],
				d ^ mdl.word_at(base[4] + 32'(4 * k)));
			check(mdl.wmem[base[5] + 32'(4 * k)],
				d ^ mdl.word_at(base[5] + 32'(4 * k)));
		end
		$display("test op %0d len %0d ended", op, len);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] d;
		logic [31:0] v;
		int          k;
		n_fail = 0;
		checks_done = 0;
		n_rd = 0;
		n_wr = 0;
		d = $urandom(32'he63a4ac1);
		sys_rst_i = 1'b1;
		start_i = 1'b0;
		dcr_rd_i = 1'b0;
		dcr_wr_i = 1'b0;
		dcr_addr_i = 10'h0;
		dcr_wdata_i = 32'h0;
		repeat (4) @(posedge ref_clk_i);
		#1 sys_rst_i = 1'b0;
		for (k = 0; k < 12; k++)
		begin
			dcr_rd(raid6_ctrl_pkg::OFS_REQUEST + 10'(k), d);
			check(d, raid6_ctrl_pkg::REG_RESET);
		end
		for (k = 1; k < 13; k++)
		begin
			v = $urandom;
			dcr_wr(raid6_ctrl_pkg::OFS_REQUEST + 10'(k), v);
			dcr_rd(raid6_ctrl_pkg::OFS_REQUEST + 10'(k), d);
			check(d, (k == 9 || k == 12) ? 32'h0 : v);
			if (k == 1)
				check(lost_members_o, v[4:0]);
			if (k == 10)
				check(lamp_o, v[0]);
		end
		for (k = 0; k < 5; k++)
		begin
			dcr_wr(raid6_ctrl_pkg::OFS_LOST, 32'h1 << k);
			check(lost_members_o, 32'h1 << k);
		end
		$display("test registers ended");
		for (k = 0; k < 6; k++)
		begin
			base[k] = (32'(k + 1) << 16) | ($urandom & 32'h0000_0ffc);
			dcr_wr(raid6_ctrl_pkg::OFS_DATA_ONE + 10'(k), base[k]);
		end
		dcr_wr(raid6_ctrl_pkg::OFS_OP_SEL, {raid6_ctrl_pkg::OP_UPDATE, 29'h0});
		dcr_wr(raid6_ctrl_pkg::OFS_REQUEST, 32'h1);
		repeat (20) @(posedge ref_clk_i);
		#1 dcr_rd(raid6_ctrl_pkg::OFS_REQUEST, d);
		check(d, 32'h1);
		check(n_rd, 0);
		dcr_wr(raid6_ctrl_pkg::OFS_REQUEST, 32'h0);
		$display("test start gate ended");
		start_i = 1'b1;
		for (k = 0; k < 8; k++)
			if (k != 3)
				run_op(3'(k), 5'h00);
		run_op(raid6_ctrl_pkg::OP_UPDATE, raid6_ctrl_pkg::LEN_512);
		run_op(raid6_ctrl_pkg::OP_UPDATE, raid6_ctrl_pkg::LEN_1K);
		run_op(raid6_ctrl_pkg::OP_UPDATE, raid6_ctrl_pkg::LEN_2K);
		run_op(raid6_ctrl_pkg::OP_UPDATE, 5'h03);
		print_verdict();
	end

	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		n_fail++;
		print_verdict();
	end
endmodule
`default_nettype wire

// ### sim/upd_ctrl_sva.sv
// port assertions for the parity update control block
`timescale 1ns/10ps
`default_nettype none
module upd_ctrl_sva
(
	input wire logic        ref_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        start_i,
	input wire logic [9:0]  dcr_addr_i,
	input wire logic        dcr_rd_i,
	input wire logic        dcr_wr_i,
	input wire logic [31:0] dcr_wdata_i,
	input wire logic [31:0] dcr_rdata_o,
	input wire logic        dcr_ack_o,
	input wire logic        mem_req_o,
	input wire logic        mem_rnw_o,
	input wire logic [31:0] mem_addr_o,
	input wire logic        mem_ack_i,
	input wire logic        mem_wr_valid_o,
	input wire logic [31:0] mem_wr_data_o,
	input wire logic        mem_wr_ready_i,
	input wire logic        mem_wr_cmpl_i,
	input wire logic        done_o,
	input wire logic        lamp_o,
	input wire logic [4:0]  lost_members_o
);
	logic wr_open;

	// write burst granted, completion not yet seen
	always_ff @(posedge ref_clk_i)
		if (sys_rst_i)
			wr_open <= 1'b0;
		else if (mem_req_o && mem_ack_i && !mem_rnw_o)
			wr_open <= 1'b1;
		else if (mem_wr_cmpl_i)
			wr_open <= 1'b0;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_dcr_ack_timing: assert property (
		dcr_ack_o == $past(dcr_rd_i || dcr_wr_i))
		else $error("register ack not one cycle after strobe");
	a_rsvd_reads_zero: assert property (
		dcr_rd_i && dcr_addr_i == raid6_ctrl_pkg::OFS_RESERVED
		|=> dcr_rdata_o == 32'h0) else $error("reserved slot not zero");
	a_req_field_only: assert property (
		dcr_rd_i && dcr_addr_i == raid6_ctrl_pkg::OFS_REQUEST
		|=> dcr_rdata_o[31:1] == 31'h0) else $error("request upper bits");
	a_lost_decode: assert property (
		dcr_wr_i && dcr_addr_i == raid6_ctrl_pkg::OFS_LOST
		|=> ##1 lost_members_o == $past(dcr_wdata_i[4:0], 2))
		else $error("lost member decode wrong");
	a_lamp_level: assert property (
		dcr_wr_i && dcr_addr_i == raid6_ctrl_pkg::OFS_LAMP
		|=> lamp_o == $past(dcr_wdata_i[0])) else $error("lamp level wrong");
	a_req_stands: assert property (
		mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
		&& $stable(mem_rnw_o)) else $error("burst request dropped early");
	a_wdata_stands: assert property (
		mem_wr_valid_o && !mem_wr_ready_i |=> mem_wr_valid_o
		&& $stable(mem_wr_data_o)) else $error("write word not held");
	a_done_quiet: assert property (
		done_o |-> !mem_req_o && !mem_wr_valid_o)
		else $error("memory traffic while done");
	a_clear_after_cmpl: assert property (
		$rose(done_o) |-> !wr_open) else $error("done before write ack");
	a_start_gate: assert property (
		$fell(done_o) |-> $past(start_i)) else $error("run without start");

	c_run_done: cover property ($rose(done_o));
	c_write_cmpl: cover property (mem_wr_cmpl_i && wr_open);
	c_rsvd_read: cover property (dcr_rd_i
		&& dcr_addr_i == raid6_ctrl_pkg::OFS_RESERVED);
endmodule
bind raid6_parity_update_control upd_ctrl_sva chk (.*);
`default_nettype wire
